// ---- src/asb_params.svh ----
// Register offsets, field positions, reset values and bit timing
`ifndef ASB_PARAMS_SVH
`define ASB_PARAMS_SVH
`define ASB_A_DATA 10'h3f8
`define ASB_A_IER 10'h3f9
`define ASB_A_IIR 10'h3fa
`define ASB_A_LCR 10'h3fb
`define ASB_A_MCR 10'h3fc
`define ASB_A_LSR 10'h3fd
`define ASB_A_MSR 10'h3fe
`define ASB_LCR_DIVISOR_ACCESS_BIT 7
`define ASB_LCR_SBRK 6
`define ASB_LCR_STICK 5
`define ASB_LCR_EVEN 4
`define ASB_LCR_PEN 3
`define ASB_LCR_STB 2
`define ASB_MCR_LOOP 4
`define ASB_MCR_OUT2 3
`define ASB_MCR_OUT1 2
`define ASB_MCR_RTS 1
`define ASB_MCR_DTR 0
`define ASB_IER_MS 3
`define ASB_IER_LS 2
`define ASB_IER_THR 1
`define ASB_IER_RDA 0
`define ASB_DIV_RST 16'h0001
`define ASB_LCR_RST 8'h03
`define ASB_IER_RST 4'h0
`define ASB_MCR_RST 5'h00
`define ASB_BIT_LAST 6'h0f
`define ASB_BIT_MID 6'h07
`define ASB_STOP15_LAST 6'h17
`define ASB_STOP2_LAST 6'h1f
`endif

// ---- src/asb_pkg.sv ----
// Types shared by the serial controller
package asb_pkg;
    typedef enum logic [2:0] {
        SER_IDLE = 3'b000,
        SER_START = 3'b001,
        SER_DATA = 3'b010,
        SER_PAR = 3'b011,
        SER_STOP = 3'b100
    } asb_ser_st_t;
    typedef enum logic [2:0] {
        IID_LSR = 3'b110,
        IID_RDA = 3'b100,
        IID_THR = 3'b010,
        IID_MSR = 3'b000,
        IID_NONE = 3'b001
    } asb_iid_t;
endpackage

// ---- src/asb_uart.sv ----
// Asynchronous serial controller with status, modem lines and baud generator
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "asb_params.svh"

module asb_uart
    import asb_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [9:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [7:0] o_rd_data,
    input wire logic i_serial_rx_pin,
    output logic o_serial_tx_pin,
    input wire logic i_cts_n,
    input wire logic i_dsr_n,
    input wire logic i_ri_n,
    input wire logic i_receive_line_signal_detect_n,
    output logic o_dtr_n,
    output logic o_rts_n,
    output logic o_out1_n,
    output logic o_out2_n,
    output logic o_irq
);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic rst_meta_ff, rst_n_ff;
    logic [7:0] dll_ff, dlm_ff, lcr_ff, thr_ff, rbr_ff, rd_data_ff;
    logic [15:0] baud_cnt_ff;
    logic [3:0] ier_ff, msr_q_ff, delta_ff, msr_in, nxt_delta;
    logic [4:0] mcr_ff;
    logic holding_reg_empty_flag_ff, thri_ack_ff, dr_ff, oe_ff, pe_ff, fe_ff, bi_ff;
    logic msr_vld_ff, irq_ff, tx_pin_ff;
    logic [3:0] modem_n_ff;
    asb_ser_st_t tx_st_ff, rx_st_ff;
    asb_iid_t iid;
    logic [5:0] tx_cnt_ff, rx_cnt_ff, tx_last, rx_last;
    logic [2:0] tx_bit_ff, rx_bit_ff, last_bit;
    logic [7:0] tx_sh_ff, rx_sh_ff, rx_data, brk_cnt_ff, frame_ticks;
    logic tx_par_ff, rx_pe_ff, rx_mark_ff, tx_line, rx_in;
    logic tick, tx_end, rx_end, tx_load, rx_done, temt, loop;
    logic wr_thr, wr_dll, wr_dlm, rd_rbr, rd_iir, rd_lsr, rd_msr;
    logic set_pe, set_fe, set_bi, set_oe, int_ls;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!rst_n_ff);

    if (DIV_W != 16) begin : g_chk
        $error("asb_uart: divisor must be 16 bits wide");
    end

    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ---------------------------------------------------------------
    // Register decode
    // ---------------------------------------------------------------
    assign loop = mcr_ff[`ASB_MCR_LOOP];
    assign wr_thr = i_wr_en && i_addr == `ASB_A_DATA && !lcr_ff[`ASB_LCR_DIVISOR_ACCESS_BIT];
    assign wr_dll = i_wr_en && i_addr == `ASB_A_DATA && lcr_ff[`ASB_LCR_DIVISOR_ACCESS_BIT];
    assign wr_dlm = i_wr_en && i_addr == `ASB_A_IER && lcr_ff[`ASB_LCR_DIVISOR_ACCESS_BIT];
    assign rd_rbr = i_rd_en && i_addr == `ASB_A_DATA && !lcr_ff[`ASB_LCR_DIVISOR_ACCESS_BIT];
    assign rd_iir = i_rd_en && i_addr == `ASB_A_IIR;
    assign rd_lsr = i_rd_en && i_addr == `ASB_A_LSR;
    assign rd_msr = i_rd_en && i_addr == `ASB_A_MSR;

    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            lcr_ff <= `ASB_LCR_RST;
            ier_ff <= `ASB_IER_RST;
            mcr_ff <= `ASB_MCR_RST;
            thr_ff <= 8'h00;
        end else if (i_wr_en) begin
            case (i_addr)
                `ASB_A_LCR: lcr_ff <= i_wr_data;
                `ASB_A_MCR: mcr_ff <= i_wr_data[4:0];
                `ASB_A_IER: if (!lcr_ff[`ASB_LCR_DIVISOR_ACCESS_BIT]) ier_ff <= i_wr_data[3:0];
                `ASB_A_DATA: if (wr_thr) thr_ff <= i_wr_data;
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Baud generator: one tick per 1/16 bit
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            dll_ff <= 8'(`ASB_DIV_RST);
            dlm_ff <= 8'(`ASB_DIV_RST >> 8);
            baud_cnt_ff <= `ASB_DIV_RST;
        end else if (wr_dll) begin
            dll_ff <= i_wr_data;
            baud_cnt_ff <= {dlm_ff, i_wr_data};
        end else if (wr_dlm) begin
            dlm_ff <= i_wr_data;
            baud_cnt_ff <= {i_wr_data, dll_ff};
        end else if (baud_cnt_ff <= 16'h0001) begin
            baud_cnt_ff <= {dlm_ff, dll_ff};
        end else begin
            baud_cnt_ff <= baud_cnt_ff - 16'h0001;
        end
    end
    assign tick = baud_cnt_ff == 16'h0001;

    // ---------------------------------------------------------------
    // Character format
    // ---------------------------------------------------------------
    function automatic logic par_bit(input logic [7:0] d);
        if (lcr_ff[`ASB_LCR_STICK])
            return !lcr_ff[`ASB_LCR_EVEN];
        return lcr_ff[`ASB_LCR_EVEN] ? ^d : ~^d;
    endfunction

    assign last_bit = {1'b1, lcr_ff[1:0]};
    assign frame_ticks = {4'h7 + {2'h0, lcr_ff[1:0]}
        + {3'h0, lcr_ff[`ASB_LCR_PEN]} + {3'h0, lcr_ff[`ASB_LCR_STB]}, 4'h0};

    // ---------------------------------------------------------------
    // Transmitter
    // ---------------------------------------------------------------
    assign tx_load = tx_st_ff == SER_IDLE && !holding_reg_empty_flag_ff;
    assign tx_last = tx_st_ff != SER_STOP ? `ASB_BIT_LAST
        : !lcr_ff[`ASB_LCR_STB] ? `ASB_BIT_LAST
        : lcr_ff[1:0] == 2'h0 ? `ASB_STOP15_LAST : `ASB_STOP2_LAST;
    assign tx_end = tick && tx_cnt_ff == tx_last;
    assign temt = holding_reg_empty_flag_ff && tx_st_ff == SER_IDLE;

    always_comb begin
        case (tx_st_ff)
            SER_START: tx_line = 1'b0;
            SER_DATA: tx_line = tx_sh_ff[0];
            SER_PAR: tx_line = tx_par_ff;
            default: tx_line = 1'b1;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            tx_st_ff <= SER_IDLE;
            tx_cnt_ff <= 6'h00;
            tx_bit_ff <= 3'h0;
            tx_sh_ff <= 8'h00;
            tx_par_ff <= 1'b0;
        end else begin
            if (tx_st_ff == SER_IDLE || tx_end)
                tx_cnt_ff <= 6'h00;
            else if (tick)
                tx_cnt_ff <= tx_cnt_ff + 6'h01;
            case (tx_st_ff)
                SER_IDLE: if (tx_load) begin
                    tx_st_ff <= SER_START;
                    tx_sh_ff <= thr_ff & (8'hff >> (2'h3 - lcr_ff[1:0]));
                    tx_par_ff <= par_bit(thr_ff &
                        (8'hff >> (2'h3 - lcr_ff[1:0])));
                end
                SER_START: if (tx_end) begin
                    tx_st_ff <= SER_DATA;
                    tx_bit_ff <= 3'h0;
                end
                SER_DATA: if (tx_end) begin
                    tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                    tx_bit_ff <= tx_bit_ff + 3'h1;
                    if (tx_bit_ff == last_bit)
                        tx_st_ff <= lcr_ff[`ASB_LCR_PEN] ? SER_PAR : SER_STOP;
                end
                SER_PAR: if (tx_end) tx_st_ff <= SER_STOP;
                SER_STOP: if (tx_end) tx_st_ff <= SER_IDLE;
                default: tx_st_ff <= SER_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            holding_reg_empty_flag_ff <= 1'b1;
            thri_ack_ff <= 1'b0;
        end else begin
            if (wr_thr)
                holding_reg_empty_flag_ff <= 1'b0;
            else if (tx_load)
                holding_reg_empty_flag_ff <= 1'b1;
            if (wr_thr)
                thri_ack_ff <= 1'b0;
            else if (rd_iir && iid == IID_THR)
                thri_ack_ff <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Receiver
    // ---------------------------------------------------------------
    assign rx_in = loop ? tx_line : i_serial_rx_pin;
    assign rx_last = rx_st_ff == SER_START ? `ASB_BIT_MID : `ASB_BIT_LAST;
    assign rx_end = tick && rx_cnt_ff == rx_last;
    assign rx_done = rx_st_ff == SER_STOP && rx_end;
    assign rx_data = rx_sh_ff >> (2'h3 - lcr_ff[1:0]);

    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rx_st_ff <= SER_IDLE;
            rx_cnt_ff <= 6'h00;
            rx_bit_ff <= 3'h0;
            rx_sh_ff <= 8'h00;
            rx_pe_ff <= 1'b0;
            rx_mark_ff <= 1'b0;
        end else begin
            if (rx_st_ff == SER_IDLE || rx_end)
                rx_cnt_ff <= 6'h00;
            else if (tick)
                rx_cnt_ff <= rx_cnt_ff + 6'h01;
            if (rx_in)
                rx_mark_ff <= 1'b1;
            else if (rx_done)
                rx_mark_ff <= 1'b0;
            case (rx_st_ff)
                SER_IDLE: if (tick && !rx_in && rx_mark_ff) begin
                    rx_st_ff <= SER_START;
                    rx_pe_ff <= 1'b0;
                end
                SER_START: if (rx_end) begin
                    rx_st_ff <= rx_in ? SER_IDLE : SER_DATA;
                    rx_bit_ff <= 3'h0;
                end
                SER_DATA: if (rx_end) begin
                    rx_sh_ff <= {rx_in, rx_sh_ff[7:1]};
                    rx_bit_ff <= rx_bit_ff + 3'h1;
                    if (rx_bit_ff == last_bit)
                        rx_st_ff <= lcr_ff[`ASB_LCR_PEN] ? SER_PAR : SER_STOP;
                end
                SER_PAR: if (rx_end) begin
                    rx_pe_ff <= rx_in != par_bit(rx_data);
                    rx_st_ff <= SER_STOP;
                end
                SER_STOP: if (rx_end) rx_st_ff <= SER_IDLE;
                default: rx_st_ff <= SER_IDLE;
            endcase
        end
    end

    // Break: low for a whole frame, counted in ticks
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff)
            brk_cnt_ff <= 8'h00;
        else if (rx_in)
            brk_cnt_ff <= 8'h00;
        else if (tick && brk_cnt_ff != 8'hff)
            brk_cnt_ff <= brk_cnt_ff + 8'h01;
    end

    // ---------------------------------------------------------------
    // Line status; hardware set wins over read clear
    // ---------------------------------------------------------------
    assign set_pe = rx_done && lcr_ff[`ASB_LCR_PEN] && rx_pe_ff;
    assign set_fe = rx_done && !rx_in;
    assign set_oe = rx_done && dr_ff;
    assign set_bi = tick && !rx_in && brk_cnt_ff == frame_ticks;

    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rbr_ff <= 8'h00;
            dr_ff <= 1'b0;
            oe_ff <= 1'b0;
            pe_ff <= 1'b0;
            fe_ff <= 1'b0;
            bi_ff <= 1'b0;
        end else begin
            if (rx_done)
                rbr_ff <= rx_data;
            dr_ff <= rx_done || (dr_ff && !rd_rbr);
            oe_ff <= set_oe || (oe_ff && !rd_lsr);
            pe_ff <= set_pe || (pe_ff && !rd_lsr);
            fe_ff <= set_fe || (fe_ff && !rd_lsr);
            bi_ff <= set_bi || (bi_ff && !rd_lsr);
        end
    end

    // ---------------------------------------------------------------
    // Modem status
    // ---------------------------------------------------------------
    assign msr_in = loop
        ? {mcr_ff[`ASB_MCR_OUT2], mcr_ff[`ASB_MCR_OUT1],
           mcr_ff[`ASB_MCR_DTR], mcr_ff[`ASB_MCR_RTS]}
        : ~{i_receive_line_signal_detect_n, i_ri_n,
            i_dsr_n, i_cts_n};
    assign nxt_delta = msr_vld_ff
        ? {msr_in[3] ^ msr_q_ff[3], msr_q_ff[2] & !msr_in[2],
           msr_in[1] ^ msr_q_ff[1], msr_in[0] ^ msr_q_ff[0]}
        : 4'h0;

    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            msr_q_ff <= 4'h0;
            msr_vld_ff <= 1'b0;
            delta_ff <= 4'h0;
        end else begin
            msr_q_ff <= msr_in;
            msr_vld_ff <= 1'b1;
            delta_ff <= nxt_delta | (delta_ff & ~{4{rd_msr}});
        end
    end

    // ---------------------------------------------------------------
    // Interrupt priority and identification
    // ---------------------------------------------------------------
    assign int_ls = ier_ff[`ASB_IER_LS] && (oe_ff || pe_ff || fe_ff || bi_ff);

    always_comb begin
        if (int_ls)
            iid = IID_LSR;
        else if (ier_ff[`ASB_IER_RDA] && dr_ff)
            iid = IID_RDA;
        else if (ier_ff[`ASB_IER_THR] && holding_reg_empty_flag_ff && !thri_ack_ff)
            iid = IID_THR;
        else if (ier_ff[`ASB_IER_MS] && |delta_ff)
            iid = IID_MSR;
        else
            iid = IID_NONE;
    end

    // ---------------------------------------------------------------
    // Outputs and read data
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            irq_ff <= 1'b0;
            tx_pin_ff <= 1'b1;
            modem_n_ff <= 4'hf;
            rd_data_ff <= 8'h00;
        end else begin
            irq_ff <= mcr_ff[`ASB_MCR_OUT2] && iid != IID_NONE;
            if (lcr_ff[`ASB_LCR_SBRK])
                tx_pin_ff <= 1'b0;
            else
                tx_pin_ff <= loop || tx_line;
            modem_n_ff <= ~mcr_ff[3:0];
            if (!i_rd_en)
                rd_data_ff <= 8'h00;
            else begin
                case (i_addr)
                    `ASB_A_DATA: rd_data_ff <=
                        lcr_ff[`ASB_LCR_DIVISOR_ACCESS_BIT] ? dll_ff : rbr_ff;
                    `ASB_A_IER: rd_data_ff <=
                        lcr_ff[`ASB_LCR_DIVISOR_ACCESS_BIT] ? dlm_ff : {4'h0, ier_ff};
                    `ASB_A_IIR: rd_data_ff <= {5'h00, iid};
                    `ASB_A_LCR: rd_data_ff <= lcr_ff;
                    `ASB_A_MCR: rd_data_ff <= {3'h0, mcr_ff};
                    `ASB_A_LSR: rd_data_ff <= {1'b0, temt, holding_reg_empty_flag_ff, bi_ff,
                        fe_ff, pe_ff, oe_ff, dr_ff};
                    `ASB_A_MSR: rd_data_ff <= {msr_q_ff, delta_ff};
                    default: rd_data_ff <= 8'h00;
                endcase
            end
        end
    end

    assign o_rd_data = rd_data_ff;
    assign o_serial_tx_pin = tx_pin_ff;
    assign o_dtr_n = modem_n_ff[`ASB_MCR_DTR];
    assign o_rts_n = modem_n_ff[`ASB_MCR_RTS];
    assign o_out1_n = modem_n_ff[`ASB_MCR_OUT1];
    assign o_out2_n = modem_n_ff[`ASB_MCR_OUT2];
    assign o_irq = irq_ff;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    tx_empty_a: assert property (rd_lsr && temt |=> o_rd_data[6])
        else $error("transmitter empty not reported");
    holding_reg_empty_flag_clr_a: assert property (wr_thr |=> !holding_reg_empty_flag_ff
        && thr_ff == $past(i_wr_data))
        else $error("holding empty not cleared by write");
    holding_reg_empty_flag_irq_a: assert property (holding_reg_empty_flag_ff && ier_ff[1] && !thri_ack_ff
        && mcr_ff[3] |=> o_irq)
        else $error("holding empty interrupt missing");
    fe_a: assert property (rx_st_ff == SER_STOP && rx_end && !rx_in
        |=> fe_ff)
        else $error("framing error not flagged");
    pe_clr_a: assert property (rd_lsr && !set_pe |=> !pe_ff)
        else $error("parity flag not cleared by read");
    overrun_a: assert property (rx_done && dr_ff |=> oe_ff && dr_ff)
        else $error("overrun not flagged");
    loop_msr_a: assert property (loop && $stable(mcr_ff) && msr_vld_ff
        |-> msr_q_ff == {mcr_ff[3], mcr_ff[2], mcr_ff[0], mcr_ff[1]})
        else $error("loopback modem status mismatch");
    teri_a: assert property (msr_vld_ff && msr_in[2] && !delta_ff[2]
        && !msr_q_ff[2] |=> !delta_ff[2])
        else $error("ring change set on wrong edge");
    baud_load_a: assert property (wr_dll |=>
        baud_cnt_ff == {dlm_ff, dll_ff})
        else $error("divisor write did not reload counter");
    irq_gate_a: assert property (!mcr_ff[3] |=> !o_irq)
        else $error("interrupt leaked with user output 2 off");
    brk_pin_a: assert property (lcr_ff[6] |=> !o_serial_tx_pin)
        else $error("break did not hold the line low");

    char_rx_c: cover property (rx_done ##1 dr_ff);
    break_c: cover property (set_bi);
    msr_irq_c: cover property (iid == IID_MSR ##1 o_irq);

endmodule

// ---- verif/asb_modem_model.sv ----
// Modem-side model: serial receive line and handshake inputs
`timescale 1ns/1ps
module asb_modem_model (
    input wire logic i_clk_sys,
    output logic o_rx,
    output logic [3:0] o_lines_n
);
    initial begin
        o_rx = 1'h1;
        o_lines_n = 4'hf;
    end
    // Frame bits leave LSB first, each held clks cycles, then mark
    task automatic send(input logic [11:0] f, input int n, input int clks);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk_sys);
            o_rx <= f[i];
            repeat (clks - 1) @(posedge i_clk_sys);
        end
        @(posedge i_clk_sys);
        o_rx <= 1'h1;
    endtask
    // Order is carrier, ring, set-ready, clear-to-send, active low
    task automatic lines(input logic [3:0] v);
        @(posedge i_clk_sys);
        o_lines_n <= v;
    endtask
endmodule

// ---- verif/tb_asb_uart.sv ----
// Self-checking bench of the serial controller
`timescale 1ns/1ps
module tb_asb_uart;
    logic clk, rst_n, wr_en, rd_en, rx, tx, dtr_n, rts_n, o1_n, o2_n, irq;
    logic [9:0] addr;
    logic [7:0] wdata, rdata;
    logic [3:0] lines_n;
    int error_cnt = 0;
    int cmp_count = 0;
    localparam int BITC = 32;
    logic [9:0] ra [7] = '{10'h3f9, 10'h3fa, 10'h3fb, 10'h3fc, 10'h3fd,
                           10'h3fe, 10'h3ff};
    logic [7:0] re [7] = '{8'h00, 8'h01, 8'h03, 8'h00, 8'h60, 8'h00, 8'h00};
    logic [3:0] ml [6] = '{4'he, 4'hf, 4'hb, 4'hf, 4'h5, 4'hf};
    logic [7:0] me [6] = '{8'h11, 8'h01, 8'h40, 8'h04, 8'haa, 8'h0a};
    asb_uart asb_uart_inst (.i_clk_sys(clk), .i_arst_n(rst_n), .i_addr(addr),
        .i_wr_data(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .o_rd_data(rdata), .i_serial_rx_pin(rx), .o_serial_tx_pin(tx),
        .i_cts_n(lines_n[0]), .i_dsr_n(lines_n[1]), .i_ri_n(lines_n[2]),
        .i_receive_line_signal_detect_n(lines_n[3]), .o_dtr_n(dtr_n),
        .o_rts_n(rts_n), .o_out1_n(o1_n), .o_out2_n(o2_n), .o_irq(irq));
    asb_modem_model asb_modem_model_inst (.i_clk_sys(clk), .o_rx(rx),
        .o_lines_n(lines_n));
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: byte %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: bit %b want %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'h1;
        @(posedge clk);
        wr_en <= 1'h0;
    endtask
    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge clk);
        rd_en <= 1'h0;
        @(negedge clk);
        chk8(rdata, exp);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    initial begin
        #3_000_000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        {addr, wdata, wr_en, rd_en, rst_n} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        #1;
        chk8({4'h0, dtr_n, rts_n, o1_n, o2_n}, 8'h0f);
        chk1(tx, 1'h1);
        waitc(3);
        for (int i = 0; i < 7; i++) rd(ra[i], re[i]);
        // Divisor first, then format, before any traffic
        wr(10'h3fb, 8'h83);
        wr(10'h3f8, 8'h02);
        wr(10'h3f9, 8'h00);
        rd(10'h3f8, 8'h02);
        wr(10'h3fb, 8'h03);
        wr(10'h3f9, 8'h07);
        wr(10'h3fc, 8'h08);
        asb_modem_model_inst.send({3'h7, 8'h3c, 1'h0}, 10, BITC);
        rd(10'h3fa, 8'h04);
        rd(10'h3fd, 8'h61);
        rd(10'h3f8, 8'h3c);
        rd(10'h3fa, 8'h02);
        rd(10'h3fa, 8'h01);
        asb_modem_model_inst.send({3'h0, 8'h55, 1'h0}, 10, BITC);
        rd(10'h3fa, 8'h06);
        rd(10'h3fd, 8'h69);
        rd(10'h3fd, 8'h61);
        rd(10'h3f8, 8'h55);
        asb_modem_model_inst.send({3'h7, 8'h11, 1'h0}, 10, BITC);
        asb_modem_model_inst.send({3'h7, 8'h22, 1'h0}, 10, BITC);
        rd(10'h3fd, 8'h63);
        rd(10'h3f8, 8'h22);
        rd(10'h3fd, 8'h60);
        wr(10'h3fb, 8'h1b);
        asb_modem_model_inst.send({3'h2, 8'h01, 1'h0}, 11, BITC);
        rd(10'h3fd, 8'h65);
        rd(10'h3fd, 8'h61);
        rd(10'h3f8, 8'h01);
        wr(10'h3fb, 8'h03);
        asb_modem_model_inst.send(12'h000, 12, BITC);
        rd(10'h3fd, 8'h79);
        rd(10'h3f8, 8'h00);
        wr(10'h3f8, 8'ha5);
        for (int n = 0; n < 40 && tx !== 1'h0; n++) waitc(1);
        waitc(BITC / 2);
        chk1(tx, 1'h0);
        for (int i = 0; i < 8; i++) begin
            waitc(BITC);
            chk1(tx, 1'(8'ha5 >> i));
        end
        rd(10'h3fd, 8'h20);
        waitc(2 * BITC);
        rd(10'h3fd, 8'h60);
        chk1(irq, 1'h1);
        wr(10'h3fc, 8'h00);
        waitc(2);
        chk1(irq, 1'h0);
        // Set break holds the line at spacing while the transmitter idles
        wr(10'h3fb, 8'h43);
        waitc(2);
        chk1(tx, 1'h0);
        wr(10'h3fb, 8'h03);
        wr(10'h3f9, 8'h08);
        wr(10'h3fc, 8'h08);
        for (int i = 0; i < 6; i++) begin
            asb_modem_model_inst.lines(ml[i]);
            waitc(4);
            chk1(irq, me[i][3:0] != 4'h0);
            rd(10'h3fe, me[i]);
        end
        wr(10'h3fc, 8'h1f);
        waitc(3);
        chk8({4'h0, dtr_n, rts_n, o1_n, o2_n}, 8'h00);
        rd(10'h3fe, 8'hfb);
        wr(10'h3f8, 8'h5a);
        waitc(12 * BITC);
        chk1(tx, 1'h1);
        rd(10'h3f8, 8'h5a);
        print_verdict();
    end
endmodule
